// ---- logic/ecx_defines.vh ----
// constants for the eight-bit execution core
`ifndef ECX_DEFINES_VH
`define ECX_DEFINES_VH

// ==============================
// register memory placement
`define ECX_ADDR_B 8'hF0
`define ECX_ADDR_X 8'hF1
`define ECX_ADDR_SP 8'hF2
`define ECX_ADDR_SEG 8'hF3

// ==============================
// reset values and fixed addresses
`define ECX_SP_RESET 8'h6F
`define ECX_VEC_TABLE 15'h01E0
`define ECX_INT_ENTRY 15'h00FF
`define ECX_JP_BIAS 15'h001F
`define ECX_PC_ONE 15'h0001

// ==============================
// opcode classes, held in opcode bits 7..4
`define ECX_CL_ALU_IMM 4'h1
`define ECX_CL_ALU_DIR 4'h2
`define ECX_CL_ALU_IB 4'h3
`define ECX_CL_ALU_IX 4'h4
`define ECX_CL_ACC 4'h5
`define ECX_CL_BIT 4'h6
`define ECX_CL_LDBS 4'h7
`define ECX_CL_COND 4'h8
`define ECX_CL_CTRL 4'h9
`define ECX_CL_LDX 4'hA
`define ECX_JP_TAG 2'h3
`define ECX_BIT_SET_POS 3

// ==============================
// alu operations
`define ECX_ALU_ADD 4'h0
`define ECX_ALU_ADC 4'h1
`define ECX_ALU_SUBTRACT_WITH_CARRY_OP 4'h2
`define ECX_ALU_AND 4'h3
`define ECX_ALU_OR 4'h4
`define ECX_ALU_XOR 4'h5
`define ECX_ALU_RRC 4'h6
`define ECX_ALU_RLC 4'h7
`define ECX_ALU_SWAP 4'h8

// ==============================
// sub-operations, opcode bits 3..0
`define ECX_ACC_CLR 4'h3
`define ECX_ACC_SC 4'h4
`define ECX_ACC_RC 4'h5
`define ECX_ACC_IFC 4'h6
`define ECX_ACC_IFNC 4'h7
`define ECX_COND_EQ 4'h0
`define ECX_COND_NE 4'h1
`define ECX_COND_GT 4'h2
`define ECX_COND_ANDSZ 4'h3
`define ECX_COND_EQ_B 4'h4
`define ECX_CTRL_JSR 4'h0
`define ECX_CTRL_RET 4'h1
`define ECX_CTRL_RETURN_AND_SKIP_OP 4'h2
`define ECX_CTRL_RETURN_FROM_INTERRUPT_OP 4'h3
`define ECX_CTRL_VIS 4'h4
`define ECX_CTRL_JMPL 4'h5
`define ECX_CTRL_LDPCL 4'h6
`define ECX_LDX_A_IMM 4'h0
`define ECX_LDX_A_DIR 4'h1
`define ECX_LDX_XCH_B 4'h2
`define ECX_LDX_B_IMM 4'h3
`define ECX_LDX_X_IMM 4'h4
`define ECX_LDX_A_IX 4'h5

`endif

// ---- logic/ecx_alu.v ----
// accumulator arithmetic, logic, rotate and swap
`timescale 1ns/10ps
`include "ecx_defines.vh"

module ecx_alu (
  input wire [3:0] alu_op,
  input wire [7:0] acc,
  input wire [7:0] operand,
  input wire carry_in,
  output reg [7:0] result,
  output reg carry_out,
  output reg half_out,
  output reg carry_upd,
  output reg half_upd
);

  // ==============================
  // shared adder; subtract is add of the complement plus carry
  wire is_sub = (alu_op == `ECX_ALU_SUBTRACT_WITH_CARRY_OP);
  wire [7:0] m_eff = is_sub ? ~operand : operand;
  wire cin_eff = (alu_op == `ECX_ALU_ADD) ? 1'b0 : carry_in;
  wire [8:0] sum9 = {1'b0, acc} + {1'b0, m_eff} + {8'h00, cin_eff};
  wire [4:0] nib5 = {1'b0, acc[3:0]} + {1'b0, m_eff[3:0]} + {4'h0, cin_eff};

  always @* begin
    result = acc;
    carry_out = carry_in;
    half_out = 1'b0;
    carry_upd = 1'b0;
    half_upd = 1'b0;
    case (alu_op)
      `ECX_ALU_ADD, `ECX_ALU_ADC, `ECX_ALU_SUBTRACT_WITH_CARRY_OP: begin
        // RULE_12 - carry and half carry
        result = sum9[7:0];
        carry_out = sum9[8];
        half_out = nib5[4];
        carry_upd = (alu_op != `ECX_ALU_ADD);
        half_upd = (alu_op != `ECX_ALU_ADD);
      end
      `ECX_ALU_AND: result = acc & operand;
      `ECX_ALU_OR: result = acc | operand;
      // RULE_05 - full bitwise xor
      `ECX_ALU_XOR: result = acc ^ operand;
      // RULE_06 - rotates through carry
      `ECX_ALU_RRC: begin
        result = {carry_in, acc[7:1]};
        carry_out = acc[0];
        carry_upd = 1'b1;
      end
      `ECX_ALU_RLC: begin
        result = {acc[6:0], carry_in};
        carry_out = acc[7];
        carry_upd = 1'b1;
      end
      // RULE_06 - nibble exchange
      `ECX_ALU_SWAP: result = {acc[3:0], acc[7:4]};
      default: result = acc;
    endcase
  end

endmodule // ecx_alu

// ---- logic/ecx_decode.v ----
// instruction length decode from the opcode byte
`timescale 1ns/10ps
`include "ecx_defines.vh"

module ecx_decode (
  input wire [7:0] opcode,
  output reg [1:0] instr_len
);

  always @* begin
    instr_len = 2'd1;
    if (opcode[7:6] != `ECX_JP_TAG) begin
      case (opcode[7:4])
        `ECX_CL_ALU_IMM, `ECX_CL_ALU_DIR: instr_len = 2'd2;
        `ECX_CL_COND: instr_len = (opcode[3:0] <= `ECX_COND_ANDSZ) ? 2'd2 : 2'd1;
        `ECX_CL_CTRL: begin
          if (opcode[3:0] == `ECX_CTRL_JSR || opcode[3:0] == `ECX_CTRL_JMPL)
            instr_len = 2'd3;
        end
        `ECX_CL_LDX: begin
          if (opcode[3:0] == `ECX_LDX_A_IMM || opcode[3:0] == `ECX_LDX_A_DIR ||
              opcode[3:0] == `ECX_LDX_B_IMM || opcode[3:0] == `ECX_LDX_X_IMM)
            instr_len = 2'd2;
        end
        default: instr_len = 2'd1;
      endcase
    end
  end

endmodule // ecx_decode

// ---- logic/ecx_core.v ----
// eight-bit core: fetch, skip, stack, interrupt dispatch and execution
//
// Notes on behaviour
// RULE_01 - a skipped instruction is still fetched, then executed as a no-op
// RULE_02 - true condition runs next instruction; false condition skips it
// RULE_03 - subroutine call pushes program counter before loading target
// RULE_04 - all returns pop top of stack into program counter
// RULE_05 - xor is fully bitwise; xor with all ones complements accumulator
// RULE_06 - rotate right/left through carry and nibble swap of accumulator
// RULE_07 - set or clear one memory bit, number 0 to 7, others kept
// RULE_08 - program counter is 15 bits: 7-bit upper and 8-bit lower part
// RULE_09 - register memory at F0..F3 holds both pointers and stack pointer
// RULE_10 - status word holds carry, half carry and interrupt enable bits
// RULE_11 - alu operand is direct byte, byte at first pointer, or immediate
// RULE_12 - add with carry sets carry out and half carry from bit 3
// RULE_13 - both pointers address data memory indirectly for operands
// RULE_14 - vector select reads two adjacent program bytes into program counter
// RULE_15 - short immediate load of first pointer clears its high nibble
// RULE_16 - one-byte relative jump spans -31 to +32 from its own address
// RULE_17 - one pending-skip flag, set by failed test, cleared after squash
`timescale 1ns/10ps
`include "ecx_defines.vh"

module ecx_core (
  input wire clk,
  input wire reset,
  output reg [14:0] pmem_addr,
  input wire [7:0] pmem_rdata,
  output reg [7:0] dmem_addr,
  output reg [7:0] dmem_wdata,
  output reg dmem_we,
  input wire [7:0] dmem_rdata,
  input wire int_request,
  input wire [3:0] int_vector_index,
  output reg int_ack,
  output reg [7:0] accumulator,
  output reg [7:0] first_index_pointer,
  output reg [7:0] second_index_pointer,
  output reg [7:0] segment_select,
  output reg [7:0] stack_pointer,
  output reg [6:0] program_counter_high,
  output reg [7:0] program_counter_low,
  output reg carry_flag,
  output reg half_carry_flag,
  output reg global_interrupt_enable,
  output reg skip_pending
);

  // ==============================
  // states
  localparam S_FETCH = 5'd0;
  localparam S_DECODE = 5'd1;
  localparam S_OPND1 = 5'd2;
  localparam S_OPND2 = 5'd3;
  localparam S_DISPATCH = 5'd4;
  localparam S_MEMRD = 5'd5;
  localparam S_EXEC = 5'd6;
  localparam S_WRITE = 5'd7;
  localparam S_PUSHLO = 5'd8;
  localparam S_PUSHHI = 5'd9;
  localparam S_JUMP = 5'd10;
  localparam S_POP1 = 5'd11;
  localparam S_POP2 = 5'd12;
  localparam S_POP3 = 5'd13;
  localparam S_VIS1 = 5'd14;
  localparam S_VIS2 = 5'd15;
  localparam S_VIS3 = 5'd16;

  reg [4:0] state;
  reg [4:0] ret_state;
  reg [7:0] opcode;
  reg [7:0] imm1;
  reg [7:0] imm2;
  reg [7:0] operand;
  reg [7:0] w_addr;
  reg [7:0] w_data;
  reg [7:0] byte_high;
  reg [14:0] instr_pc;
  reg [14:0] target;

  // ==============================
  // helpers
  wire [14:0] pc_full = {program_counter_high, program_counter_low};
  wire [14:0] pc_plus1 = pc_full + `ECX_PC_ONE;
  wire [3:0] op_class = opcode[7:4];
  wire [3:0] op_sub = opcode[3:0];
  wire is_jp = (opcode[7:6] == `ECX_JP_TAG);
  wire [1:0] fetched_len;
  wire [1:0] skip_extra = fetched_len - 2'd1;
  // RULE_16 - field 0..63 biased to -31..+32
  wire [14:0] jp_target = instr_pc + {9'h000, opcode[5:0]} - `ECX_JP_BIAS;
  // RULE_14 - two-byte vectors, adjacent addresses
  wire [14:0] vec_addr = `ECX_VEC_TABLE + {10'h000, int_vector_index, 1'b0};

  ecx_decode u_decode (
    .opcode(pmem_rdata),
    .instr_len(fetched_len)
  );

  reg [3:0] alu_op;
  always @* begin
    if (op_class == `ECX_CL_ACC)
      alu_op = `ECX_ALU_RRC + {2'b00, op_sub[1:0]};
    else
      alu_op = {1'b0, op_sub[2:0]};
  end

  wire [7:0] alu_result;
  wire alu_carry;
  wire alu_half;
  wire alu_carry_upd;
  wire alu_half_upd;

  ecx_alu u_alu (
    .alu_op(alu_op),
    .acc(accumulator),
    .operand(operand),
    .carry_in(carry_flag),
    .result(alu_result),
    .carry_out(alu_carry),
    .half_out(alu_half),
    .carry_upd(alu_carry_upd),
    .half_upd(alu_half_upd)
  );

  // RULE_07 - one bit replaced, others kept
  wire [7:0] bit_result;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      assign bit_result[gi] = (op_sub[2:0] == gi) ? op_sub[`ECX_BIT_SET_POS] : operand[gi];
    end
  endgenerate

  // RULE_09 - register memory answers from core registers
  reg [7:0] rd_val;
  always @* begin
    case (dmem_addr)
      `ECX_ADDR_B: rd_val = first_index_pointer;
      `ECX_ADDR_X: rd_val = second_index_pointer;
      `ECX_ADDR_SP: rd_val = stack_pointer;
      `ECX_ADDR_SEG: rd_val = segment_select;
      default: rd_val = dmem_rdata;
    endcase
  end

  // RULE_02 - condition evaluation
  reg cond_true;
  always @* begin
    case (op_sub)
      `ECX_COND_EQ, `ECX_COND_EQ_B: cond_true = (accumulator == operand);
      `ECX_COND_NE: cond_true = (accumulator != operand);
      `ECX_COND_GT: cond_true = (accumulator > operand);
      `ECX_COND_ANDSZ: cond_true = ((accumulator & operand) != 8'h00);
      default: cond_true = 1'b1;
    endcase
  end

  // ==============================
  // sequencer
  always @(posedge clk) begin
    if (reset) begin
      state <= S_FETCH;
      ret_state <= S_FETCH;
      opcode <= 8'h00;
      imm1 <= 8'h00;
      imm2 <= 8'h00;
      operand <= 8'h00;
      w_addr <= 8'h00;
      w_data <= 8'h00;
      byte_high <= 8'h00;
      instr_pc <= 15'h0000;
      target <= 15'h0000;
      pmem_addr <= 15'h0000;
      dmem_addr <= 8'h00;
      dmem_wdata <= 8'h00;
      dmem_we <= 1'b0;
      int_ack <= 1'b0;
      accumulator <= 8'h00;
      first_index_pointer <= 8'h00;
      second_index_pointer <= 8'h00;
      segment_select <= 8'h00;
      stack_pointer <= `ECX_SP_RESET;
      program_counter_high <= 7'h00;
      program_counter_low <= 8'h00;
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      global_interrupt_enable <= 1'b0;
      skip_pending <= 1'b0;
    end else begin
      dmem_we <= 1'b0;
      int_ack <= 1'b0;
      case (state)
        S_FETCH: begin
          // interrupts wait until a pending squash is done
          if (global_interrupt_enable && int_request && !skip_pending) begin
            // RULE_10 - enable dropped on entry
            global_interrupt_enable <= 1'b0;
            int_ack <= 1'b1;
            target <= `ECX_INT_ENTRY;
            state <= S_PUSHLO;
          end else begin
            pmem_addr <= pc_full;
            instr_pc <= pc_full;
            {program_counter_high, program_counter_low} <= pc_plus1;
            state <= S_DECODE;
          end
        end
        S_DECODE: begin
          opcode <= pmem_rdata;
          if (skip_pending) begin
            // RULE_01 - fetched, operands stepped over, no effect
            // RULE_17 - flag cleared once squashed
            skip_pending <= 1'b0;
            {program_counter_high, program_counter_low} <= pc_full + {13'h0000, skip_extra};
            state <= S_FETCH;
          end else if (fetched_len != 2'd1) begin
            pmem_addr <= pc_full;
            {program_counter_high, program_counter_low} <= pc_plus1;
            state <= S_OPND1;
          end else begin
            state <= S_DISPATCH;
          end
        end
        S_OPND1: begin
          imm1 <= pmem_rdata;
          if (op_class == `ECX_CL_CTRL) begin
            pmem_addr <= pc_full;
            {program_counter_high, program_counter_low} <= pc_plus1;
            state <= S_OPND2;
          end else begin
            state <= S_DISPATCH;
          end
        end
        S_OPND2: begin
          imm2 <= pmem_rdata;
          state <= S_DISPATCH;
        end
        S_DISPATCH: begin
          state <= S_FETCH;
          if (is_jp) begin
            {program_counter_high, program_counter_low} <= jp_target;
          end else begin
            case (op_class)
              // RULE_11 - immediate, direct or first pointer operand
              `ECX_CL_ALU_IMM: begin
                operand <= imm1;
                state <= S_EXEC;
              end
              `ECX_CL_ALU_DIR: begin
                dmem_addr <= imm1;
                state <= S_MEMRD;
              end
              // RULE_13 - either pointer addresses the operand
              `ECX_CL_ALU_IB, `ECX_CL_BIT: begin
                dmem_addr <= first_index_pointer;
                state <= S_MEMRD;
              end
              `ECX_CL_ALU_IX: begin
                dmem_addr <= second_index_pointer;
                state <= S_MEMRD;
              end
              `ECX_CL_ACC: begin
                case (op_sub)
                  `ECX_ACC_CLR: accumulator <= 8'h00;
                  `ECX_ACC_SC: carry_flag <= 1'b1;
                  `ECX_ACC_RC: carry_flag <= 1'b0;
                  // RULE_02 - carry tests
                  `ECX_ACC_IFC: skip_pending <= ~carry_flag;
                  `ECX_ACC_IFNC: skip_pending <= carry_flag;
                  default: begin
                    accumulator <= alu_result;
                    if (alu_carry_upd)
                      carry_flag <= alu_carry;
                  end
                endcase
              end
              // RULE_15 - high nibble forced to zero
              `ECX_CL_LDBS: first_index_pointer <= {4'h0, op_sub};
              `ECX_CL_COND: begin
                if (op_sub == `ECX_COND_EQ_B) begin
                  dmem_addr <= first_index_pointer;
                  state <= S_MEMRD;
                end else begin
                  operand <= imm1;
                  state <= S_EXEC;
                end
              end
              `ECX_CL_CTRL: begin
                case (op_sub)
                  `ECX_CTRL_JSR: begin
                    target <= {imm1[6:0], imm2};
                    state <= S_PUSHLO;
                  end
                  `ECX_CTRL_RET, `ECX_CTRL_RETURN_AND_SKIP_OP, `ECX_CTRL_RETURN_FROM_INTERRUPT_OP: state <= S_POP1;
                  `ECX_CTRL_VIS: state <= S_VIS1;
                  `ECX_CTRL_JMPL: {program_counter_high, program_counter_low} <= {imm1[6:0], imm2};
                  // RULE_08 - lower part altered alone
                  `ECX_CTRL_LDPCL: program_counter_low <= accumulator;
                  default: state <= S_FETCH;
                endcase
              end
              `ECX_CL_LDX: begin
                case (op_sub)
                  `ECX_LDX_A_IMM: accumulator <= imm1;
                  `ECX_LDX_A_DIR: begin
                    dmem_addr <= imm1;
                    state <= S_MEMRD;
                  end
                  `ECX_LDX_XCH_B: begin
                    dmem_addr <= first_index_pointer;
                    state <= S_MEMRD;
                  end
                  `ECX_LDX_B_IMM: first_index_pointer <= imm1;
                  `ECX_LDX_X_IMM: second_index_pointer <= imm1;
                  `ECX_LDX_A_IX: begin
                    dmem_addr <= second_index_pointer;
                    state <= S_MEMRD;
                  end
                  default: state <= S_FETCH;
                endcase
              end
              default: state <= S_FETCH;
            endcase
          end
        end
        S_MEMRD: begin
          operand <= rd_val;
          state <= S_EXEC;
        end
        S_EXEC: begin
          state <= S_FETCH;
          case (op_class)
            `ECX_CL_ALU_IMM, `ECX_CL_ALU_DIR, `ECX_CL_ALU_IB, `ECX_CL_ALU_IX: begin
              accumulator <= alu_result;
              if (alu_carry_upd)
                carry_flag <= alu_carry;
              if (alu_half_upd)
                half_carry_flag <= alu_half;
            end
            // RULE_02 - failed test arms the skip
            // RULE_17 - single pending flag
            `ECX_CL_COND: skip_pending <= ~cond_true;
            `ECX_CL_BIT: begin
              w_addr <= dmem_addr;
              w_data <= bit_result;
              ret_state <= S_FETCH;
              state <= S_WRITE;
            end
            `ECX_CL_LDX: begin
              accumulator <= operand;
              if (op_sub == `ECX_LDX_XCH_B) begin
                w_addr <= dmem_addr;
                w_data <= accumulator;
                ret_state <= S_FETCH;
                state <= S_WRITE;
              end
            end
            default: state <= S_FETCH;
          endcase
        end
        S_WRITE: begin
          // RULE_09 - writes to pointer addresses land in core registers
          case (w_addr)
            `ECX_ADDR_B: first_index_pointer <= w_data;
            `ECX_ADDR_X: second_index_pointer <= w_data;
            `ECX_ADDR_SP: stack_pointer <= w_data;
            `ECX_ADDR_SEG: segment_select <= w_data;
            default: begin
              dmem_addr <= w_addr;
              dmem_wdata <= w_data;
              dmem_we <= 1'b1;
            end
          endcase
          state <= ret_state;
        end
        // RULE_03 - push low then high, jump afterwards
        S_PUSHLO: begin
          w_addr <= stack_pointer;
          w_data <= program_counter_low;
          stack_pointer <= stack_pointer - 8'h01;
          ret_state <= S_PUSHHI;
          state <= S_WRITE;
        end
        S_PUSHHI: begin
          w_addr <= stack_pointer;
          w_data <= {1'b0, program_counter_high};
          stack_pointer <= stack_pointer - 8'h01;
          ret_state <= S_JUMP;
          state <= S_WRITE;
        end
        S_JUMP: begin
          {program_counter_high, program_counter_low} <= target;
          state <= S_FETCH;
        end
        // RULE_04 - pop high then low into program counter
        S_POP1: begin
          stack_pointer <= stack_pointer + 8'h01;
          dmem_addr <= stack_pointer + 8'h01;
          state <= S_POP2;
        end
        S_POP2: begin
          byte_high <= rd_val;
          stack_pointer <= stack_pointer + 8'h01;
          dmem_addr <= stack_pointer + 8'h01;
          state <= S_POP3;
        end
        S_POP3: begin
          {program_counter_high, program_counter_low} <= {byte_high[6:0], rd_val};
          if (op_sub == `ECX_CTRL_RETURN_AND_SKIP_OP)
            skip_pending <= 1'b1;
          if (op_sub == `ECX_CTRL_RETURN_FROM_INTERRUPT_OP)
            global_interrupt_enable <= 1'b1;
          state <= S_FETCH;
        end
        // RULE_14 - vector upper byte then lower byte
        S_VIS1: begin
          pmem_addr <= vec_addr;
          state <= S_VIS2;
        end
        S_VIS2: begin
          byte_high <= pmem_rdata;
          pmem_addr <= pmem_addr + `ECX_PC_ONE;
          state <= S_VIS3;
        end
        S_VIS3: begin
          {program_counter_high, program_counter_low} <= {byte_high[6:0], pmem_rdata};
          state <= S_FETCH;
        end
        default: state <= S_FETCH;
      endcase
    end
  end

endmodule // ecx_core

// ---- dv/ecx_core_properties.sv ----
// assertions on the execution core ports
`timescale 1ns/10ps
module ecx_core_properties (
  input wire clk,
  input wire reset,
  input wire [14:0] pmem_addr,
  input wire [7:0] dmem_addr,
  input wire dmem_we,
  input wire int_request,
  input wire int_ack,
  input wire [7:0] accumulator,
  input wire [7:0] first_index_pointer,
  input wire [7:0] stack_pointer,
  input wire [6:0] program_counter_high,
  input wire [7:0] program_counter_low,
  input wire carry_flag,
  input wire global_interrupt_enable,
  input wire skip_pending
);
  // ====================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_RESET_VALUES: assert property (
    $fell(reset) |-> stack_pointer == 8'h6F && accumulator == 8'h00
      && !global_interrupt_enable && pmem_addr == 15'h0000) else $error("bad reset state");
  AST_REGMEM_OFF_BUS: assert property (
    dmem_we |-> dmem_addr[7:2] != 6'h3C) else $error("register memory on bus");
  AST_ACK_PULSE: assert property (
    int_ack |=> !int_ack) else $error("ack too long");
  AST_ACK_CAUSE: assert property (
    int_ack |-> $past(global_interrupt_enable) && $past(int_request)
      && !global_interrupt_enable) else $error("ack without cause");
  AST_ACK_PUSH: assert property (
    int_ack |-> ##[0:8] dmem_we) else $error("no push on entry");
  AST_ACK_ENTRY: assert property (
    int_ack |-> ##[0:12] {program_counter_high, program_counter_low} == 15'h00FF)
    else $error("no entry address");
  AST_ACK_NOT_SKIP: assert property (
    int_ack |-> !$past(skip_pending)) else $error("entry during skip");
  AST_SKIP_CLEARS: assert property (
    $rose(skip_pending) |-> ##[1:12] !skip_pending) else $error("skip stuck");
  AST_SKIP_NO_WRITE: assert property (
    skip_pending |-> !dmem_we) else $error("write while squashed");
  AST_SKIP_NO_EFFECT: assert property (
    skip_pending |=> $stable({accumulator, carry_flag, first_index_pointer}))
    else $error("state changed while squashed");
  cover property (int_ack);
  cover property ($rose(skip_pending));
  cover property (dmem_we);
endmodule // ecx_core_properties

// ---- dv/ecx_mem_model.sv ----
// program and data memory behind the core
`timescale 1ns/10ps
module ecx_mem_model (
  input wire clk,
  input wire [14:0] pmem_addr,
  output logic [7:0] pmem_rdata,
  input wire [7:0] dmem_addr,
  input wire [7:0] dmem_wdata,
  input wire dmem_we,
  output logic [7:0] dmem_rdata
);
  // small program store; upper addresses alias, enough for the tests
  logic [7:0] pmem [0:511];
  logic [7:0] dmem [0:255];
  assign pmem_rdata = pmem[pmem_addr[8:0]];
  assign dmem_rdata = dmem[dmem_addr];
  always @(posedge clk) begin
    if (dmem_we) dmem[dmem_addr] <= dmem_wdata;
  end
endmodule // ecx_mem_model

// ---- dv/testbench.sv ----
// self-checking bench for the execution core
`timescale 1ns/10ps
`include "ecx_defines.vh"
module testbench;
  typedef logic [7:0] ecx_bytes_t [];
  logic clk = 0, reset = 1, int_request = 0;
  logic [3:0] int_vector_index = 4'h0;
  logic [14:0] pmem_addr;
  logic [7:0] pmem_rdata, dmem_addr, dmem_wdata, dmem_rdata, accumulator, first_index_pointer;
  logic [7:0] second_index_pointer, segment_select, stack_pointer, program_counter_low;
  logic [6:0] program_counter_high;
  logic dmem_we, int_ack, carry_flag, half_carry_flag, global_interrupt_enable, skip_pending;
  int errors = 0, n_checks = 0, acks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (int_ack === 1'b1) acks <= acks + 1;
  ecx_mem_model ecx_mem_model_inst (.clk, .pmem_addr, .pmem_rdata, .dmem_addr, .dmem_wdata,
    .dmem_we, .dmem_rdata);
  ecx_core ecx_core_inst (.clk, .reset, .pmem_addr, .pmem_rdata, .dmem_addr, .dmem_wdata,
    .dmem_we, .dmem_rdata, .int_request, .int_vector_index, .int_ack, .accumulator,
    .first_index_pointer, .second_index_pointer, .segment_select, .stack_pointer,
    .program_counter_high, .program_counter_low, .carry_flag, .half_carry_flag,
    .global_interrupt_enable, .skip_pending);
  // ====================
  // helpers
  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic load(input logic [14:0] at, input ecx_bytes_t b);
    foreach (b[i]) ecx_mem_model_inst.pmem[at + i] = b[i];
  endtask
  task automatic start();
    @(negedge clk);
    reset = 1;
    acks = 0;
    foreach (ecx_mem_model_inst.pmem[i]) ecx_mem_model_inst.pmem[i] = 8'h00;
    foreach (ecx_mem_model_inst.dmem[i]) ecx_mem_model_inst.dmem[i] = 8'h00;
    repeat (16) @(negedge clk);
  endtask
  // halt is a jump to itself; wait till it has run once
  task automatic go(input logic [14:0] halt, input string name);
    int n;
    n = 0;
    reset = 0;
    for (int k = 0; k < 3; k++) begin
      while ((({program_counter_high, program_counter_low} === halt) == (k == 1))
          && n < 3000) begin
        @(negedge clk);
        n++;
      end
    end
    if (n >= 3000) begin
      errors++;
      $display("mismatch halt of %s expected %h seen timeout", name, halt);
    end
    $display("test %s done", name);
  endtask
  // ====================
  // scenarios
  task automatic t_alu();
    start();
    ecx_mem_model_inst.dmem[3] = 8'h10;
    ecx_mem_model_inst.dmem[4] = 8'hFF;
    load(0, '{8'hA3, 8'hF7, 8'h73, 8'hA0, 8'h3C, 8'h54, 8'h31, 8'h11, 8'h0F, 8'h25, 8'h04,
      8'hDF});
    go(15'h000B, "alu");
    check("acc", 15'h00A3, accumulator);
    check("carry", 15'h0000, carry_flag);
    check("half", 15'h0001, half_carry_flag);
    check("ptr", 15'h0003, first_index_pointer);
  endtask
  task automatic t_rot();
    start();
    load(0, '{8'hA0, 8'h81, 8'h55, 8'h50, 8'h50, 8'h51, 8'h52, 8'hDF});
    go(15'h0007, "rotate");
    check("acc", 15'h0004, accumulator);
    check("carry", 15'h0001, carry_flag);
  endtask
  task automatic t_bit();
    start();
    ecx_mem_model_inst.dmem[5] = 8'h81;
    load(0, '{8'h75, 8'h6B, 8'h62, 8'h60, 8'h6F, 8'hA3, 8'hF3, 8'h6C, 8'hA4, 8'h05, 8'hA5,
      8'hA3, 8'hF1, 8'h60, 8'hDF});
    go(15'h000E, "bits");
    check("mem", 15'h0088, ecx_mem_model_inst.dmem[5]);
    check("acc", 15'h0088, accumulator);
    check("seg", 15'h0010, segment_select);
    check("x", 15'h0004, second_index_pointer);
    check("bus", 15'h0000, ecx_mem_model_inst.dmem[8'hF3]);
  endtask
  task automatic t_sub();
    start();
    load(0, '{8'hA0, 8'h50, 8'h54, 8'h12, 8'h21, 8'h57, 8'h10, 8'h01, 8'h83, 8'hD0, 8'h10,
      8'h02, 8'h56, 8'h10, 8'h10, 8'hDF});
    go(15'h000F, "subtract");
    check("acc", 15'h003F, accumulator);
    check("carry", 15'h0001, carry_flag);
    check("half", 15'h0000, half_carry_flag);
  endtask
  task automatic t_skip();
    start();
    load(0, '{8'hA0, 8'h07, 8'h80, 8'h07, 8'h10, 8'h01, 8'h80, 8'h07, 8'h6B, 8'h81, 8'h07,
      8'h10, 8'h10, 8'hDF});
    go(15'h000D, "skip");
    check("acc", 15'h0018, accumulator);
    check("mem", 15'h0000, ecx_mem_model_inst.dmem[0]);
    check("pending", 15'h0000, skip_pending);
  endtask
  task automatic t_call();
    start();
    load(0, '{8'h90, 8'h00, 8'h20, 8'h90, 8'h00, 8'h30, 8'h10, 8'h01, 8'hDF});
    load(15'h0020, '{8'hA0, 8'h55, 8'h91});
    load(15'h0030, '{8'h92});
    go(15'h0008, "call");
    check("acc", 15'h0055, accumulator);
    check("sp", 15'h006F, stack_pointer);
    check("low", 15'h0006, ecx_mem_model_inst.dmem[8'h6F]);
    check("high", 15'h0000, ecx_mem_model_inst.dmem[8'h6E]);
  endtask
  task automatic t_int();
    start();
    int_request = 1;
    int_vector_index = 4'h2;
    load(0, '{8'h90, 8'h00, 8'h20, 8'hDF});
    load(15'h0020, '{8'h93});
    load(`ECX_INT_ENTRY, '{8'h94});
    load(`ECX_VEC_TABLE + 15'h0004, '{8'h00, 8'h40});
    load(15'h0040, '{8'hA0, 8'h77, 8'hDF});
    go(15'h0042, "vector");
    int_request = 0;
    check("acc", 15'h0077, accumulator);
    check("gie", 15'h0000, global_interrupt_enable);
    check("acks", 15'h0001, acks[14:0]);
  endtask
  task automatic t_jump();
    start();
    load(0, '{8'h95, 8'h01, 8'h00});
    load(15'h0100, '{8'hFF, 8'hDF});
    load(15'h0120, '{8'hC0});
    go(15'h0101, "jump");
    check("pc_high", 15'h0001, program_counter_high);
    check("pc_low", 15'h0001, program_counter_low);
  endtask
  // ====================
  // run control
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    t_alu();
    t_rot();
    t_bit();
    t_skip();
    t_sub();
    t_call();
    t_int();
    t_jump();
    tally_and_finish();
  end
endmodule // testbench
bind ecx_core ecx_core_properties ecx_core_properties_inst (.clk, .reset, .pmem_addr,
  .dmem_addr, .dmem_we, .int_request, .int_ack, .accumulator, .first_index_pointer,
  .stack_pointer, .program_counter_high, .program_counter_low, .carry_flag,
  .global_interrupt_enable, .skip_pending);
